// *** hdl/bsd_boot_strap_decoder.sv ***
/*
  Boot strap decoder top: captures straps at reset release, drives the
  decoded configuration to internal consumers, exposes it over Avalon-MM.
  Assumes strap pins are static near reset release and synchronous to
  core_clk; rst is the system reset input.
*/
`default_nettype none
module bsd_boot_strap_decoder (
  input wire logic core_clk,
  input wire logic rst,
  // strap pins
  input wire logic test_enable_strap,
  input wire logic debug_port_select_strap,
  input wire logic por_enable_strap,
  input wire logic cpu_reset_bypass,
  input wire logic pll_power_down,
  input wire logic pll_bypass,
  input wire logic [2:0] software_strap,
  input wire logic [1:0] boot_source_strap,
  input wire logic reset_wait_long_strap,
  input wire logic usb_boot_request_n,
  input wire logic sdcard_boot_request_n,
  // decoded outputs
  output logic sys_reset,
  output logic scan_test_enable,
  output logic jtag_to_debug,
  output logic factory_jtag,
  output logic por_gen_enable,
  output logic cpu_reset_logic_bypass,
  output logic pll_powered_down,
  output logic pll_bypassed,
  output logic [2:0] boot_select,
  output logic reset_wait_done,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ************************************************************
  // strap capture
  // ************************************************************
  logic captured_q;
  logic cap_pulse;
  logic test_en_q;
  logic dbg_sel_q;
  logic por_en_q;
  logic cpu_byp_q;
  logic pll_pd_q;
  logic pll_byp_q;
  logic [2:0] sw_q;
  logic [1:0] src_q;
  logic wait_long_q;
  logic usb_n_q;
  logic sd_n_q;
  bsd_pkg::bsd_boot_e boot_sel;
  logic wait_done;

  // first clock after release samples pins; async reset only loads constants
  assign cap_pulse = !captured_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      captured_q <= 1'b0;
    end else begin
      captured_q <= 1'b1;
    end
  end

  // reset values are the documented pull defaults
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      test_en_q <= 1'b0;
      dbg_sel_q <= 1'b0;
      por_en_q <= 1'b1;
      cpu_byp_q <= 1'b0;
      pll_pd_q <= 1'b0;
      pll_byp_q <= 1'b0;
      sw_q <= 3'h0;
      src_q <= bsd_pkg::BSD_SRC_EMMC;
      wait_long_q <= 1'b0;
      usb_n_q <= 1'b1;
      sd_n_q <= 1'b1;
    end else if (cap_pulse) begin
      test_en_q <= test_enable_strap;
      dbg_sel_q <= debug_port_select_strap;
      por_en_q <= por_enable_strap;
      cpu_byp_q <= cpu_reset_bypass;
      pll_pd_q <= pll_power_down;
      pll_byp_q <= pll_bypass;
      sw_q <= software_strap;
      src_q <= boot_source_strap;
      wait_long_q <= reset_wait_long_strap;
      usb_n_q <= usb_boot_request_n;
      sd_n_q <= sdcard_boot_request_n;
    end
  end

  // ************************************************************
  // decode
  // ************************************************************
  bsd_boot_decode u_decode (
    .src(src_q),
    .usb_boot_request_n(usb_n_q),
    .sdcard_boot_request_n(sd_n_q),
    .boot(boot_sel)
  );

  bsd_wait_timer u_wait (
    .core_clk(core_clk),
    .rst(rst),
    .start(cap_pulse),
    .length(reset_wait_long_strap ?
      bsd_pkg::BSD_WAIT_W'(bsd_pkg::BSD_WAIT_LONG_CYC) :
      bsd_pkg::BSD_WAIT_W'(bsd_pkg::BSD_WAIT_SHORT_CYC)),
    .done(wait_done)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scan_test_enable <= 1'b0;
      jtag_to_debug <= 1'b1;
      factory_jtag <= 1'b0;
      por_gen_enable <= 1'b1;
      cpu_reset_logic_bypass <= 1'b0;
      pll_powered_down <= 1'b0;
      pll_bypassed <= 1'b0;
      boot_select <= 3'h0;
      reset_wait_done <= 1'b0;
    end else begin
      scan_test_enable <= test_en_q;
      jtag_to_debug <= !test_en_q && !dbg_sel_q;
      factory_jtag <= dbg_sel_q;
      por_gen_enable <= por_en_q;
      cpu_reset_logic_bypass <= cpu_byp_q;
      pll_powered_down <= pll_pd_q;
      pll_bypassed <= pll_byp_q;
      boot_select <= boot_sel;
      reset_wait_done <= wait_done;
    end
  end

  // ************************************************************
  // avalon-mm slave
  // ************************************************************
  logic ack_q;
  logic [31:0] scratch_q;
  logic [31:0] rd_d;

  // one wait state: request taken on the edge where ack_q is high
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_comb begin
    rd_d = bsd_pkg::BSD_UNMAPPED;
    if (avs_address == bsd_pkg::BSD_REG_STRAP) begin
      rd_d[bsd_pkg::BSD_F_TEST_EN] = test_en_q;
      rd_d[bsd_pkg::BSD_F_DBG_SEL] = dbg_sel_q;
      rd_d[bsd_pkg::BSD_F_POR_EN] = por_en_q;
      rd_d[bsd_pkg::BSD_F_CPU_BYP] = cpu_byp_q;
      rd_d[bsd_pkg::BSD_F_PLL_PD] = pll_pd_q;
      rd_d[bsd_pkg::BSD_F_PLL_BYP] = pll_byp_q;
      rd_d[bsd_pkg::BSD_F_SW_LO +: 3] = sw_q;
      rd_d[bsd_pkg::BSD_F_WAIT_LONG] = wait_long_q;
      rd_d[bsd_pkg::BSD_F_SRC_LO +: 2] = src_q;
      rd_d[bsd_pkg::BSD_F_USB_N] = usb_n_q;
      rd_d[bsd_pkg::BSD_F_SD_N] = sd_n_q;
    end else if (avs_address == bsd_pkg::BSD_REG_BOOT) begin
      rd_d[2:0] = boot_sel;
    end else if (avs_address == bsd_pkg::BSD_REG_STATUS) begin
      rd_d[bsd_pkg::BSD_F_WAIT_DONE] = wait_done;
      rd_d[bsd_pkg::BSD_F_CAPTURED] = captured_q;
      // flag only: the board is expected to avoid this pairing
      rd_d[bsd_pkg::BSD_F_PLL_WARN] = pll_pd_q && !pll_byp_q;
    end else if (avs_address == bsd_pkg::BSD_REG_SCRATCH) begin
      rd_d = scratch_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rd_d;
    end
  end

  // scratch is the only writable word; strap fields are read-only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scratch_q <= 32'h0000_0000;
    end else if (avs_write && ack_q &&
                 avs_address == bsd_pkg::BSD_REG_SCRATCH) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i]) begin
          scratch_q[i*8 +: 8] <= avs_writedata[i*8 +: 8];
        end
      end
    end
  end
endmodule : bsd_boot_strap_decoder
`default_nettype wire

// *** hdl/bsd_pkg.sv ***
/*
  Constants, register map and enumerations for the boot strap decoder.
  Assumes a 50 MHz core clock and a 32-bit Avalon-MM register slave.
*/
`default_nettype none
package bsd_pkg;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [3:0] BSD_REG_STRAP = 4'h0;
  localparam logic [3:0] BSD_REG_BOOT = 4'h4;
  localparam logic [3:0] BSD_REG_STATUS = 4'h8;
  localparam logic [3:0] BSD_REG_SCRATCH = 4'hC;
  // ************************************************************
  // strap register fields
  // ************************************************************
  localparam int BSD_F_TEST_EN = 0;
  localparam int BSD_F_DBG_SEL = 1;
  localparam int BSD_F_POR_EN = 2;
  localparam int BSD_F_CPU_BYP = 3;
  localparam int BSD_F_PLL_PD = 4;
  localparam int BSD_F_PLL_BYP = 5;
  localparam int BSD_F_SW_LO = 6;
  localparam int BSD_F_WAIT_LONG = 9;
  localparam int BSD_F_SRC_LO = 10;
  localparam int BSD_F_USB_N = 12;
  localparam int BSD_F_SD_N = 13;
  // status fields
  localparam int BSD_F_WAIT_DONE = 0;
  localparam int BSD_F_CAPTURED = 1;
  localparam int BSD_F_PLL_WARN = 2;
  localparam logic [31:0] BSD_UNMAPPED = 32'h0000_0000;
  // ************************************************************
  // boot source encodings
  // ************************************************************
  localparam logic [1:0] BSD_SRC_SPI_SEC = 2'h0;
  localparam logic [1:0] BSD_SRC_NAND = 2'h1;
  localparam logic [1:0] BSD_SRC_EMMC = 2'h2;
  localparam logic [1:0] BSD_SRC_SPI_CLR = 2'h3;
  typedef enum logic [2:0] {
    BSD_BOOT_SPI_SECURE,
    BSD_BOOT_NAND,
    BSD_BOOT_EMMC,
    BSD_BOOT_SPI_CLEAR,
    BSD_BOOT_USB,
    BSD_BOOT_SDCARD
  } bsd_boot_e;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int BSD_CLK_HZ = 50_000_000;
  localparam int BSD_WAIT_SHORT_MS = 2;
  localparam int BSD_WAIT_LONG_MS = 20;
  localparam int BSD_WAIT_SHORT_CYC = BSD_CLK_HZ / 1000 * BSD_WAIT_SHORT_MS;
  localparam int BSD_WAIT_LONG_CYC = BSD_CLK_HZ / 1000 * BSD_WAIT_LONG_MS;
  localparam int BSD_WAIT_W = 20;
endpackage : bsd_pkg
`default_nettype wire

// *** hdl/bsd_wait_timer.sv ***
/*
  Reset wait timer: counts the chosen wait after strap capture.
  Assumes start is a one-cycle pulse in the core clock domain.
*/
`default_nettype none
module bsd_wait_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [bsd_pkg::BSD_WAIT_W-1:0] length,
  output logic done
);
  logic [bsd_pkg::BSD_WAIT_W-1:0] cnt_q;
  logic run_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_q <= length;
      run_q <= 1'b1;
      done <= 1'b0;
    end else if (run_q) begin
      if (cnt_q <= bsd_pkg::BSD_WAIT_W'(1)) begin
        run_q <= 1'b0;
        done <= 1'b1;
      end else begin
        cnt_q <= cnt_q - bsd_pkg::BSD_WAIT_W'(1);
      end
    end
  end
endmodule : bsd_wait_timer
`default_nettype wire

// *** hdl/bsd_boot_decode.sv ***
/*
  Boot source decoder: combines override requests with the source straps.
  Assumes all inputs are already latched values.
*/
`default_nettype none
module bsd_boot_decode (
  input wire logic [1:0] src,
  input wire logic usb_boot_request_n,
  input wire logic sdcard_boot_request_n,
  output bsd_pkg::bsd_boot_e boot
);
  always_comb begin
    // usb override ranks above sd: the button is the deliberate act
    if (!usb_boot_request_n) begin
      boot = bsd_pkg::BSD_BOOT_USB;
    end else if (!sdcard_boot_request_n) begin
      boot = bsd_pkg::BSD_BOOT_SDCARD;
    end else begin
      case (src)
        bsd_pkg::BSD_SRC_SPI_SEC: boot = bsd_pkg::BSD_BOOT_SPI_SECURE;
        bsd_pkg::BSD_SRC_NAND: boot = bsd_pkg::BSD_BOOT_NAND;
        bsd_pkg::BSD_SRC_EMMC: boot = bsd_pkg::BSD_BOOT_EMMC;
        default: boot = bsd_pkg::BSD_BOOT_SPI_CLEAR;
      endcase
    end
  end
endmodule : bsd_boot_decode
`default_nettype wire

// *** verification/bsd_checker_assertions.sv ***
/* Checker for the boot strap decoder top: capture and decode.
   Assumes binding to bsd_boot_strap_decoder, one clock domain. */
`default_nettype none
module bsd_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic test_enable_strap,
  input wire logic debug_port_select_strap,
  input wire logic por_enable_strap,
  input wire logic cpu_reset_bypass,
  input wire logic pll_power_down,
  input wire logic pll_bypass,
  input wire logic [1:0] boot_source_strap,
  input wire logic usb_boot_request_n,
  input wire logic sdcard_boot_request_n,
  input wire logic sys_reset,
  input wire logic scan_test_enable,
  input wire logic jtag_to_debug,
  input wire logic factory_jtag,
  input wire logic por_gen_enable,
  input wire logic cpu_reset_logic_bypass,
  input wire logic pll_powered_down,
  input wire logic pll_bypassed,
  input wire logic [2:0] boot_select,
  input wire logic reset_wait_done
);
  // ********************
  // capture mirror
  // ********************
  logic [1:0] cnt_q;
  logic [9:0] cap_q;
  logic live;
  assign live = cnt_q == 2'h2;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
    end else if (!live) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // same edge as the design: first edge after release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_q <= 10'h0;
    end else if (cnt_q == 2'h0) begin
      cap_q <= {sdcard_boot_request_n, usb_boot_request_n,
        boot_source_strap, pll_bypass, pll_power_down, cpu_reset_bypass,
        por_enable_strap, debug_port_select_strap, test_enable_strap};
    end
  end
  logic [bsd_pkg::BSD_WAIT_W-1:0] since_q;
  // cycles since release, parks at all ones instead of wrapping
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      since_q <= '0;
    end else if (since_q != '1) begin
      since_q <= since_q + bsd_pkg::BSD_WAIT_W'(1);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sys_release_a: assert property (!rst |=> !sys_reset)
    else $error("system reset stuck after release");
  test_map_a: assert property (live |-> scan_test_enable == cap_q[0])
    else $error("scan enable wrong");
  debug_map_a: assert property (live |->
    jtag_to_debug == (!cap_q[0] && !cap_q[1]) &&
    factory_jtag == cap_q[1])
    else $error("debug routing wrong");
  por_map_a: assert property (live |-> por_gen_enable == cap_q[2])
    else $error("por enable wrong");
  cpu_map_a: assert property (live |->
    cpu_reset_logic_bypass == cap_q[3]) else $error("cpu bypass wrong");
  pll_map_a: assert property (live |->
    pll_powered_down == cap_q[4] && pll_bypassed == cap_q[5])
    else $error("pll controls wrong");
  boot_map_a: assert property (live |->
    boot_select == (!cap_q[8] ? 3'h4 : !cap_q[9] ? 3'h5
    : {1'h0, cap_q[7:6]})) else $error("boot select wrong");
  strap_hold_a: assert property (live |=>
    $stable({boot_select, pll_bypassed, pll_powered_down, scan_test_enable}))
    else $error("decoded straps moved");
  wait_early_a: assert property (reset_wait_done |->
    since_q >= bsd_pkg::BSD_WAIT_W'(bsd_pkg::BSD_WAIT_SHORT_CYC))
    else $error("reset wait ended early");
  usb_boot_c: cover property (live && boot_select == 3'h4);
  sdcard_boot_request_c: cover property (live && boot_select == 3'h5);
  pll_warn_c: cover property (live && pll_powered_down && !pll_bypassed);
endmodule : bsd_checker
bind bsd_boot_strap_decoder bsd_checker bsd_checker_i (.core_clk, .rst,
  .test_enable_strap, .debug_port_select_strap, .por_enable_strap,
  .cpu_reset_bypass, .pll_power_down, .pll_bypass, .boot_source_strap,
  .usb_boot_request_n, .sdcard_boot_request_n, .sys_reset,
  .scan_test_enable, .jtag_to_debug, .factory_jtag, .por_gen_enable,
  .cpu_reset_logic_bypass, .pll_powered_down, .pll_bypassed, .boot_select,
  .reset_wait_done);
`default_nettype wire

// *** verification/bsd_board_model.sv ***
/* Board strap resistors and pushbuttons as one stuffing word.
   Assumes cfg uses the strap register bit layout. */
`default_nettype none
module bsd_board_model (
  input wire logic [13:0] cfg,
  input wire logic force_bad,
  output logic test_enable_strap,
  output logic debug_port_select_strap,
  output logic por_enable_strap,
  output logic cpu_reset_bypass,
  output logic pll_power_down,
  output logic pll_bypass,
  output logic [2:0] software_strap,
  output logic [1:0] boot_source_strap,
  output logic reset_wait_long_strap,
  output logic usb_boot_request_n,
  output logic sdcard_boot_request_n
);
  assign {test_enable_strap, debug_port_select_strap} = {cfg[0], cfg[1]};
  assign {por_enable_strap, cpu_reset_bypass} = {cfg[2], cfg[3]};
  assign pll_bypass = cfg[5];
  // power-down only beside bypass unless told to misbehave
  assign pll_power_down = cfg[4] & (cfg[5] | force_bad);
  assign software_strap = cfg[8:6];
  assign reset_wait_long_strap = cfg[9];
  assign boot_source_strap = cfg[11:10];
  // button held across reset release, as the operator does
  assign usb_boot_request_n = cfg[12];
  assign sdcard_boot_request_n = cfg[13];
endmodule : bsd_board_model
`default_nettype wire

// *** verification/tb_boot_strap_decoder.sv ***
/* Self-checking bench for the boot strap decoder.
   Assumes the board model and the bound checker. */
`default_nettype none
module tb_boot_strap_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst = 1'h1, bad = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic test_enable_strap, debug_port_select_strap, por_enable_strap;
  logic cpu_reset_bypass, pll_power_down, pll_bypass, reset_wait_long_strap;
  logic usb_boot_request_n, sdcard_boot_request_n, sys_reset, factory_jtag;
  logic scan_test_enable, jtag_to_debug, por_gen_enable, pll_powered_down;
  logic cpu_reset_logic_bypass, pll_bypassed, reset_wait_done;
  logic avs_waitrequest;
  logic [2:0] software_strap, boot_select;
  logic [1:0] boot_source_strap;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata, outs;
  logic [13:0] cfg = 14'h3804;
  logic [13:0] cfgs [8] = '{14'h3804, 14'h337B, 14'h3404, 14'h3C04,
    14'h0804, 14'h1404, 14'h3894, 14'h3805};
  int err_total = 0;
  int n_compared = 0;
  assign outs = {21'h0, boot_select, pll_bypassed, pll_powered_down,
    cpu_reset_logic_bypass, por_gen_enable, factory_jtag, jtag_to_debug,
    scan_test_enable, sys_reset};
  bsd_board_model bsd_board_model_i (.cfg, .force_bad(bad),
    .test_enable_strap, .debug_port_select_strap, .por_enable_strap,
    .cpu_reset_bypass, .pll_power_down, .pll_bypass, .software_strap,
    .boot_source_strap, .reset_wait_long_strap, .usb_boot_request_n,
    .sdcard_boot_request_n);
  bsd_boot_strap_decoder bsd_boot_strap_decoder_i (.core_clk, .rst,
    .test_enable_strap, .debug_port_select_strap, .por_enable_strap,
    .cpu_reset_bypass, .pll_power_down, .pll_bypass, .software_strap,
    .boot_source_strap, .reset_wait_long_strap, .usb_boot_request_n,
    .sdcard_boot_request_n, .sys_reset, .scan_test_enable, .jtag_to_debug,
    .factory_jtag, .por_gen_enable, .cpu_reset_logic_bypass,
    .pll_powered_down, .pll_bypassed, .boot_select, .reset_wait_done,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest);
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  // ********************
  // tasks
  // ********************
  task automatic close_out;
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    rdata = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 20) cmp("waitrequest", 32'h0, 32'h1);
  endtask : bus
  task automatic rd(input logic [3:0] a);
    bus(1'h0, a, 32'h0, 4'hF);
  endtask : rd
  function automatic logic [31:0] exp_out(input logic [13:0] c);
    logic [2:0] b;
    b = !c[12] ? 3'h4 : !c[13] ? 3'h5 : {1'h0, c[11:10]};
    return {21'h0, b, c[5], c[4], c[3], c[2], c[1], !(c[0] || c[1]),
      c[0], 1'h0};
  endfunction : exp_out
  // ********************
  // tests
  // ********************
  initial begin
    logic [31:0] e;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      rst <= 1'h1;
      cfg <= cfgs[i];
      bad <= (i == 6);
      repeat (12) @(posedge core_clk);
      cmp("in reset", 32'h15, outs & 32'hFF);
      rst <= 1'h0;
      repeat (3) @(posedge core_clk);
      e = exp_out(cfgs[i]);
      cmp("jtag", e & 32'hF, outs & 32'hF);
      cmp("reset pll", e & 32'hF0, outs & 32'hF0);
      cmp("boot", e >> 8, outs >> 8);
      rd(bsd_pkg::BSD_REG_STRAP);
      cmp("strap reg", {18'h0, cfgs[i]}, rdata);
      rd(bsd_pkg::BSD_REG_BOOT);
      cmp("boot reg", e >> 8, rdata);
      rd(bsd_pkg::BSD_REG_STATUS);
      cmp("status", {29'h0, cfgs[i][4] & !cfgs[i][5], 2'h2}, rdata);
      cmp("wait pin", 32'h0, {31'h0, reset_wait_done});
      cfg <= ~cfgs[i];
      repeat (3) @(posedge core_clk);
      cmp("held", e, outs);
      rd(bsd_pkg::BSD_REG_STRAP);
      cmp("held reg", {18'h0, cfgs[i]}, rdata);
    end
    bus(1'h1, bsd_pkg::BSD_REG_SCRATCH, 32'hA5A5_5A5A, 4'hF);
    bus(1'h1, bsd_pkg::BSD_REG_SCRATCH, 32'h0000_00FF, 4'h1);
    bus(1'h1, bsd_pkg::BSD_REG_STRAP, 32'hFFFF_FFFF, 4'hF);
    rd(bsd_pkg::BSD_REG_SCRATCH);
    cmp("scratch", 32'hA5A5_5AFF, rdata);
    rd(bsd_pkg::BSD_REG_STRAP);
    cmp("strap written", {18'h0, cfgs[7]}, rdata);
    rd(4'h2);
    cmp("unmapped", bsd_pkg::BSD_UNMAPPED, rdata);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    close_out();
  end
endmodule : tb_boot_strap_decoder
`default_nettype wire
